/* File: i2csrp_pkg.sv */
// Purpose: shared constants and types of the two-wire slave register port
// Assumes: 250 MHz core clock, bus clock sampled as an ordinary input
// Notes: widths here are defaults; modules take them as parameters
package i2csrp_pkg;
   // ----------------------------------------------------------------
   // addressing
   // ----------------------------------------------------------------
   localparam int PTR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam logic DIR_READ = 1'h1;
   localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
   localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;

   // ----------------------------------------------------------------
   // bit counting
   // ----------------------------------------------------------------
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // ----------------------------------------------------------------
   // buffering and timing
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 8;
   localparam int CORE_MHZ = 250;
   localparam int STD_RATE_KHZ = 100;
   localparam int FAST_RATE_KHZ = 400;
   // core cycles in the shortest bus clock period (rounded down)
   localparam int FAST_SCL_CYC = (CORE_MHZ * 1000) / FAST_RATE_KHZ;
   localparam int STD_SCL_CYC = (CORE_MHZ * 1000) / STD_RATE_KHZ;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT} i2csrp_state_t;
   typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} i2csrp_kind_t;
endpackage

/* File: i2csrp_strm_if.sv */
// Purpose: valid/ready stream between the port's own modules
// Assumes: one clock domain
// Notes: a word moves on a cycle with valid and ready both high
`timescale 1ns/10ps
interface i2csrp_strm_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: i2csrp_fifo.sv */
// Purpose: small first-in first-out buffer for received register writes
// Assumes: width and depth set by parameters, depth a power of two
// Notes: ready drops when full, valid only when not empty
`timescale 1ns/10ps
module i2csrp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // streams
   i2csrp_strm_if.snk in_s,
   i2csrp_strm_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ZERO_F = '0;

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_s.ready = (cnt_r != FULL_CNT);
   assign out_s.valid = (cnt_r != CNT_ZERO_F);
   assign out_s.data = mem_r[rptr_r];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wptr_r] <= in_s.data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + AW'(1);
         end
         if (pop) begin
            rptr_r <= rptr_r + AW'(1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - (AW+1)'(1);
         end
      end
   end
endmodule // i2csrp_fifo

/* File: i2csrp_regmem.sv */
// Purpose: register store read by the serial port
// Assumes: one write port, one read port, same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/10ps
module i2csrp_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_r
);
   logic [DW-1:0] mem_r [2**AW];

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= mem_r[raddr];
      end
   end
endmodule // i2csrp_regmem

/* File: i2csrp_top.sv */
// Purpose: two-wire bus slave giving a bus master access to a register store
// Assumes: bus pins sampled by core_clk; bus clock well below core rate
// Notes: register writes leave through a buffered stream and land in the store
`timescale 1ns/10ps
module i2csrp_top
   import i2csrp_pkg::*;
#(
   parameter int PW = PTR_W,
   parameter int DW = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // register write stream
   output logic reg_wr_valid,
   input wire logic reg_wr_ready,
   output logic [PW-1:0] reg_wr_addr,
   output logic [DW-1:0] reg_wr_data,
   // status
   output logic bus_busy,
   output logic [PW-1:0] reg_ptr
);
   // ----------------------------------------------------------------
   // pin synchronisers and bus events
   // ----------------------------------------------------------------
   logic scl_m_r, scl_s_r, scl_d_r;
   logic sda_m_r, sda_s_r, sda_d_r;
   logic scl_rise, scl_fall, start_det, stop_det;

   // three core cycles of latency is far below a fast-mode half period
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_m_r <= 1'h1;
         scl_s_r <= 1'h1;
         scl_d_r <= 1'h1;
         sda_m_r <= 1'h1;
         sda_s_r <= 1'h1;
         sda_d_r <= 1'h1;
      end else begin
         scl_m_r <= scl_i;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_i;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   assign scl_rise = scl_s_r && !scl_d_r;
   assign scl_fall = !scl_s_r && scl_d_r;
   assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
   assign stop_det = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

   // ----------------------------------------------------------------
   // protocol state
   // ----------------------------------------------------------------
   i2csrp_state_t state_r;
   i2csrp_kind_t kind_r;
   logic [3:0] rx_cnt_r;
   logic [3:0] tx_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_sh_r;
   logic rd_dir_r;
   logic mack_r;
   logic sda_oe_r;
   logic [PW-1:0] ptr_r;
   logic [DW-1:0] rdata_r;
   logic byte_done, addr_hit, ack_now, push_req, ptr_load, tx_load;

   i2csrp_strm_if #(.W(PW+DW)) push_s ();
   i2csrp_strm_if #(.W(PW+DW)) pop_s ();

   assign byte_done = (state_r == ST_RX) && scl_fall && (rx_cnt_r == BYTE_BITS);
   assign addr_hit = (rx_sh_r[7:1] == SLAVE_ADDR);
   assign push_req = byte_done && (kind_r == K_DATA);
   assign ptr_load = byte_done && (kind_r == K_PTR);
   assign tx_load = scl_fall && (((state_r == ST_RX_ACK) && (kind_r == K_ADDR) && rd_dir_r)
                    || ((state_r == ST_TX_ACK) && mack_r));

   // a full buffer refuses the byte by withholding the acknowledge
   always_comb begin
      ack_now = 1'h0;
      unique case (kind_r)
         K_ADDR: ack_now = addr_hit;
         K_PTR: ack_now = 1'h1;
         K_DATA: ack_now = push_s.ready;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         kind_r <= K_ADDR;
         rx_cnt_r <= CNT_ZERO;
         tx_cnt_r <= CNT_ZERO;
         rx_sh_r <= '0;
         tx_sh_r <= '0;
         rd_dir_r <= 1'h0;
         mack_r <= 1'h0;
         sda_oe_r <= 1'h0;
      end else if (start_det) begin
         state_r <= ST_RX;
         kind_r <= K_ADDR;
         rx_cnt_r <= CNT_ZERO;
         sda_oe_r <= 1'h0;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         sda_oe_r <= 1'h0;
      end else begin
         unique case (state_r)
            ST_IDLE, ST_WAIT: begin
               sda_oe_r <= 1'h0;
            end
            ST_RX: begin
               if (scl_rise && (rx_cnt_r != BYTE_BITS)) begin
                  rx_sh_r <= {rx_sh_r[6:0], sda_s_r};
                  rx_cnt_r <= rx_cnt_r + CNT_ONE;
               end else if (byte_done) begin
                  if ((kind_r == K_ADDR) && !addr_hit) begin
                     state_r <= ST_WAIT;
                  end else begin
                     state_r <= ST_RX_ACK;
                     sda_oe_r <= ack_now;
                     if (kind_r == K_ADDR) begin
                        rd_dir_r <= (rx_sh_r[0] == DIR_READ);
                     end
                  end
               end
            end
            ST_RX_ACK: begin
               // release only on the falling edge closing the ninth pulse
               if (tx_load) begin
                  state_r <= ST_TX;
                  tx_sh_r <= rdata_r;
                  sda_oe_r <= !rdata_r[7];
                  tx_cnt_r <= CNT_ONE;
               end else if (scl_fall) begin
                  state_r <= ST_RX;
                  rx_cnt_r <= CNT_ZERO;
                  sda_oe_r <= 1'h0;
                  kind_r <= (kind_r == K_ADDR) ? K_PTR : K_DATA;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (tx_cnt_r == BYTE_BITS) begin
                     state_r <= ST_TX_ACK;
                     sda_oe_r <= 1'h0;
                  end else begin
                     tx_sh_r <= {tx_sh_r[6:0], 1'h0};
                     sda_oe_r <= !tx_sh_r[6];
                     tx_cnt_r <= tx_cnt_r + CNT_ONE;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  mack_r <= !sda_s_r;
               end else if (tx_load) begin
                  state_r <= ST_TX;
                  tx_sh_r <= rdata_r;
                  sda_oe_r <= !rdata_r[7];
                  tx_cnt_r <= CNT_ONE;
               end else if (scl_fall) begin
                  state_r <= ST_WAIT;
                  sda_oe_r <= 1'h0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register pointer
   // ----------------------------------------------------------------
   // the pointer survives STOP so a plain read resumes where it left off
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ptr_r <= PTR_RST;
      end else if (ptr_load) begin
         ptr_r <= rx_sh_r;
      end else if (push_req && push_s.ready) begin
         ptr_r <= ptr_r + PTR_STEP;
      end else if (tx_load) begin
         ptr_r <= ptr_r + PTR_STEP;
      end
   end

   // ----------------------------------------------------------------
   // write buffer and register store
   // ----------------------------------------------------------------
   assign push_s.valid = push_req;
   assign push_s.data = {ptr_r, rx_sh_r};
   assign pop_s.ready = reg_wr_ready;

   i2csrp_fifo #(.W(PW+DW), .DEPTH(DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_s(push_s),
      .out_s(pop_s)
   );

   // writes still queued are not yet visible to reads
   i2csrp_regmem #(.AW(PW), .DW(DW)) u_mem (
      .core_clk(core_clk),
      .rst(rst),
      .we(pop_s.valid && reg_wr_ready),
      .waddr(pop_s.data[PW+DW-1:DW]),
      .wdata(pop_s.data[DW-1:0]),
      .raddr(ptr_r),
      .rdata_r(rdata_r)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign sda_o = 1'h0;
   assign sda_oe = sda_oe_r;
   assign reg_wr_valid = pop_s.valid;
   assign reg_wr_addr = pop_s.data[PW+DW-1:DW];
   assign reg_wr_data = pop_s.data[DW-1:0];
   assign bus_busy = (state_r != ST_IDLE);
   assign reg_ptr = ptr_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_ack_start;
      byte_done && ack_now && !((kind_r == K_ADDR) && !addr_hit);
   endsequence

   sequence s_ack_drive;
      (state_r == ST_RX_ACK) && sda_oe_r;
   endsequence

   a_start_claims: assert property (@(posedge core_clk) disable iff (rst)
      start_det |=> (state_r == ST_RX) && (kind_r == K_ADDR) && (rx_cnt_r == CNT_ZERO))
      else $error("start did not open an address byte");

   a_stop_frees: assert property (@(posedge core_clk) disable iff (rst)
      stop_det && !start_det |=> !bus_busy && !sda_oe_r)
      else $error("stop did not free the bus");

   a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_IDLE) |-> !sda_oe_r)
      else $error("data line driven while idle");

   a_drive_low_phase: assert property (@(posedge core_clk) disable iff (rst)
      $changed(sda_oe_r) && !$past(stop_det) && !$past(start_det) |-> !scl_s_r)
      else $error("data drive changed while clock high");

   a_bit_step: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_RX) && scl_rise && (rx_cnt_r != BYTE_BITS) && !start_det && !stop_det
      |=> rx_cnt_r == $past(rx_cnt_r) + CNT_ONE)
      else $error("received bit not counted");

   a_ack_hold: assert property (@(posedge core_clk) disable iff (rst)
      s_ack_start ##1 s_ack_drive |-> s_ack_drive until (scl_fall || start_det || stop_det))
      else $error("acknowledge released early");

   a_nack_release: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == ST_TX_ACK) && scl_fall && !mack_r && !start_det && !stop_det
      |=> (state_r == ST_WAIT) && !sda_oe_r)
      else $error("line not released after master nack");

   a_foreign_addr: assert property (@(posedge core_clk) disable iff (rst)
      byte_done && (kind_r == K_ADDR) && !addr_hit && !start_det && !stop_det
      |=> (state_r == ST_WAIT) [*2] ##0 !sda_oe_r)
      else $error("foreign address answered");

   a_ptr_load: assert property (@(posedge core_clk) disable iff (rst)
      ptr_load && !start_det && !stop_det |=> ptr_r == $past(rx_sh_r))
      else $error("pointer not loaded");

   a_ptr_write_inc: assert property (@(posedge core_clk) disable iff (rst)
      push_req && push_s.ready |=> ptr_r == $past(ptr_r) + PTR_STEP)
      else $error("pointer not stepped after write");

   a_tx_first_bit: assert property (@(posedge core_clk) disable iff (rst)
      tx_load && !start_det && !stop_det |=> (state_r == ST_TX) && (sda_oe_r == !$past(rdata_r[7]))
      && (ptr_r == $past(ptr_r) + PTR_STEP))
      else $error("read byte not started from pointer");

   a_read_mode: assert property (@(posedge core_clk) disable iff (rst)
      s_ack_start ##0 (kind_r == K_ADDR) && (rx_sh_r[0] == DIR_READ) |=> rd_dir_r && sda_oe_r)
      else $error("read address not acknowledged");
endmodule // i2csrp_top

/* File: i2csrp_mst_model.sv */
// Purpose: behavioural two-wire bus master facing the slave register port
// Assumes: open-drain data wire with pull-up resolved in the bench
// Notes: bus clock rests high between frames; half sets the rate
`timescale 1ns/10ps
module i2csrp_mst_model (
   // bus pins
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   int half = 24;
   // counts data seen changing inside a clock high phase
   int unstable = 0;

   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ---------------------------------------------------------------
   // bus conditions
   // ---------------------------------------------------------------
   // from a low clock the line is released first, giving a repeated start
   task automatic start_c();
      if (scl === 1'b0) begin
         #(half/2) sda_pull = 1'b0;
         #(half/2) scl = 1'b1;
      end
      #(half/2) sda_pull = 1'b1;
      #(half) scl = 1'b0;
   endtask

   task automatic stop_c();
      #(half/2) sda_pull = 1'b1;
      #(half/2) scl = 1'b1;
      #(half/2) sda_pull = 1'b0;
      #(half);
   endtask

   // ---------------------------------------------------------------
   // bits and bytes
   // ---------------------------------------------------------------
   // sampled twice per high phase so a mid-pulse change is caught
   task automatic bit_c(input logic b, output logic s);
      logic s1;
      #(half/2) sda_pull = ~b;
      #(half/2) scl = 1'b1;
      #2 s1 = sda;
      #(half-4) s = sda;
      if (s1 !== s) unstable++;
      #2 scl = 1'b0;
   endtask

   // tx of 8'hff leaves the line to the slave; mack pulls low in slot nine
   task automatic byte_c(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(tx[i], s);
         rx[i] = s;
      end
      bit_c(~mack, s);
      ack = ~s;
      sda_pull = 1'b0;
   endtask
endmodule // i2csrp_mst_model

/* File: i2csrp_top_test.sv */
// Purpose: self-checking bench of the two-wire slave register port
// Assumes: bus master model drives the clock pin, write stream user in bench
// Notes: every register written is drained into the store before it is read
`timescale 1ns/10ps
module i2csrp_top_test
   import i2csrp_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr_ready = 1'b0;
   logic scl;
   logic sda_pull;
   logic sda_o;
   logic sda_oe;
   logic reg_wr_valid;
   logic bus_busy;
   logic [PTR_W-1:0] reg_wr_addr;
   logic [PTR_W-1:0] reg_ptr;
   logic [DATA_W-1:0] reg_wr_data;
   wire sda;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;

   // wired-and with pull-up
   assign sda = (sda_oe | sda_pull) ? 1'b0 : 1'b1;

   always #2 core_clk = ~core_clk;

   i2csrp_top i2csrp_top_i (.core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .bus_busy(bus_busy), .reg_ptr(reg_ptr));

   i2csrp_mst_model i2csrp_mst_model_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] dval(input int i);
      return {4'(i), ~4'(i)};
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic addr(input logic [6:0] a, input logic dir, input logic exp_ack);
      logic [7:0] rx;
      logic ack;
      i2csrp_mst_model_i.start_c();
      i2csrp_mst_model_i.byte_c({a, dir}, 1'b0, rx, ack);
      check("address ack", {7'h0, exp_ack}, {7'h0, ack});
   endtask

   // user side takes exactly one word from the write stream
   task automatic pop(input logic [7:0] ea, input logic [7:0] ed);
      int n;
      n = 0;
      @(negedge core_clk);
      while (reg_wr_valid !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      check("write valid", 8'h01, {7'h0, reg_wr_valid});
      check("write addr", ea, reg_wr_addr);
      check("write data", ed, reg_wr_data);
      reg_wr_ready = 1'b1;
      @(negedge core_clk);
      reg_wr_ready = 1'b0;
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check("sda_oe", 8'h00, {7'h0, sda_oe});
      check("sda_o", 8'h00, {7'h0, sda_o});
      check("busy", 8'h00, {7'h0, bus_busy});
      check("pointer", 8'h00, reg_ptr);
      check("write valid", 8'h00, {7'h0, reg_wr_valid});
      $display("test reset done");
   endtask

   task automatic t_write();
      logic [7:0] rx;
      logic ack;
      addr(SLAVE_ADDR, 1'b0, 1'b1);
      check("busy", 8'h01, {7'h0, bus_busy});
      i2csrp_mst_model_i.byte_c(8'h10, 1'b0, rx, ack);
      check("pointer ack", 8'h01, {7'h0, ack});
      check("pointer", 8'h10, reg_ptr);
      for (int i = 0; i < 4; i++) begin
         i2csrp_mst_model_i.byte_c(dval(i), 1'b0, rx, ack);
         check("data ack", 8'h01, {7'h0, ack});
      end
      check("pointer", 8'h14, reg_ptr);
      i2csrp_mst_model_i.stop_c();
      repeat (8) @(negedge core_clk);
      check("busy", 8'h00, {7'h0, bus_busy});
      for (int i = 0; i < 4; i++) pop(8'h10 + 8'(i), dval(i));
      $display("test write done");
   endtask

   task automatic t_read();
      logic [7:0] rx;
      logic ack;
      addr(SLAVE_ADDR, 1'b0, 1'b1);
      i2csrp_mst_model_i.byte_c(8'h11, 1'b0, rx, ack);
      addr(SLAVE_ADDR, DIR_READ, 1'b1);
      i2csrp_mst_model_i.byte_c(8'hff, 1'b1, rx, ack);
      check("read byte", dval(1), rx);
      i2csrp_mst_model_i.byte_c(8'hff, 1'b0, rx, ack);
      check("read byte", dval(2), rx);
      // a wrongly loaded next byte would pull the line low by now
      repeat (8) @(negedge core_clk);
      check("released", 8'h00, {7'h0, sda_oe});
      check("pointer", 8'h13, reg_ptr);
      i2csrp_mst_model_i.stop_c();
      addr(SLAVE_ADDR, DIR_READ, 1'b1);
      i2csrp_mst_model_i.byte_c(8'hff, 1'b0, rx, ack);
      check("kept pointer read", dval(3), rx);
      i2csrp_mst_model_i.stop_c();
      check("pointer", 8'h14, reg_ptr);
      $display("test read done");
   endtask

   // stream user stalls until the buffer refuses, then drains it empty
   task automatic t_full();
      logic [7:0] rx;
      logic ack;
      addr(SLAVE_ADDR, 1'b0, 1'b1);
      i2csrp_mst_model_i.byte_c(8'h20, 1'b0, rx, ack);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         i2csrp_mst_model_i.byte_c(8'h80 + 8'(i), 1'b0, rx, ack);
         check("data ack", 8'h01, {7'h0, ack});
      end
      i2csrp_mst_model_i.byte_c(8'hee, 1'b0, rx, ack);
      check("full ack", 8'h00, {7'h0, ack});
      check("pointer", 8'h28, reg_ptr);
      i2csrp_mst_model_i.stop_c();
      for (int i = 0; i < FIFO_DEPTH; i++) pop(8'h20 + 8'(i), 8'h80 + 8'(i));
      @(negedge core_clk);
      check("write valid", 8'h00, {7'h0, reg_wr_valid});
      $display("test full done");
   endtask

   // address at 100 kHz, pointer at 400 kHz
   task automatic t_slow();
      logic [7:0] rx;
      logic ack;
      i2csrp_mst_model_i.half = 5000;
      addr(SLAVE_ADDR, 1'b0, 1'b1);
      i2csrp_mst_model_i.half = 1250;
      i2csrp_mst_model_i.byte_c(8'h30, 1'b0, rx, ack);
      check("pointer ack", 8'h01, {7'h0, ack});
      check("pointer", 8'h30, reg_ptr);
      i2csrp_mst_model_i.stop_c();
      i2csrp_mst_model_i.half = 24;
      $display("test slow done");
   endtask

   task automatic t_foreign();
      logic [7:0] rx;
      logic ack;
      addr(SLAVE_ADDR ^ 7'h01, 1'b0, 1'b0);
      i2csrp_mst_model_i.byte_c(8'h00, 1'b0, rx, ack);
      check("data ack", 8'h00, {7'h0, ack});
      addr(SLAVE_ADDR ^ 7'h40, DIR_READ, 1'b0);
      i2csrp_mst_model_i.byte_c(8'hff, 1'b0, rx, ack);
      check("silent read", 8'hff, rx);
      check("pointer", 8'h30, reg_ptr);
      i2csrp_mst_model_i.stop_c();
      repeat (8) @(negedge core_clk);
      check("busy", 8'h00, {7'h0, bus_busy});
      check("wire stable", 8'h00, 8'(i2csrp_mst_model_i.unstable));
      $display("test foreign done");
   endtask

   // ---------------------------------------------------------------
   // sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("BAD timeout expected done seen running");
         results();
      end
   end

   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      repeat (5) @(negedge core_clk);
      t_reset();
      t_write();
      t_read();
      t_full();
      t_slow();
      t_foreign();
      results();
   end
endmodule // i2csrp_top_test
